/* File: hw/crp_top.sv */
// pin routing and pad control for the five-slot card reader
`timescale 1ns/1ps
module crp_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [crp_pkg::CRP_AW-1:0] reg_addr,
  input wire logic [crp_pkg::CRP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [crp_pkg::CRP_DW-1:0] reg_rdata,
  input wire logic addr_bit1_reset_in,
  input wire logic addr_bit2_clock_in,
  input wire logic bypass_in,
  output logic low_power_mode,
  output logic [1:0] bus_addr_bits,
  input wire logic card_presence_1,
  input wire logic card_presence_2,
  output logic presence1_pullup_en,
  output logic presence2_pullup_en,
  input wire logic int_request,
  output logic int_pin_o,
  output logic int_pin_oe,
  output logic int_pullup_en,
  input wire logic [crp_pkg::CRP_SLOTS-1:0] card_clk_src,
  output logic [crp_pkg::CRP_SLOTS-1:0] card_clock_out,
  input wire logic card_reset_int_1,
  input wire logic card_reset_int_2,
  input wire logic card_reset_int_3,
  output logic card_reset_out_1,
  output logic card_reset_out_2,
  input wire logic [crp_pkg::CRP_SLOTS-1:0] card_io_line_in,
  output logic [crp_pkg::CRP_SLOTS-1:0] card_io_line_out,
  input wire logic card_c4_contact_in,
  input wire logic card_c8_contact_in,
  output logic card_c4_contact_out,
  output logic card_c8_contact_out,
  input wire logic host_io_a_i,
  output logic host_io_a_o,
  output logic host_io_a_oe,
  output logic host_io_a_pu,
  input wire logic host_io_b_i,
  output logic host_io_b_o,
  output logic host_io_b_oe,
  output logic host_io_b_pu,
  input wire logic aux_io_a_i,
  output logic aux_io_a_o,
  output logic aux_io_a_oe,
  output logic aux_io_a_pu,
  input wire logic aux_io_b_i,
  output logic aux_io_b_o,
  output logic aux_io_b_oe,
  output logic aux_io_b_pu,
  input wire logic shared_pin_slot3rst_slot2c8_i,
  output logic shared_pin_slot3rst_slot2c8_o,
  output logic shared_pin_slot3rst_slot2c8_oe,
  output logic shared_pin_slot3rst_slot2c8_pu,
  input wire logic shared_pin_slot3io_slot2c4_i,
  output logic shared_pin_slot3io_slot2c4_o,
  output logic shared_pin_slot3io_slot2c4_oe,
  output logic shared_pin_slot3io_slot2c4_pu
);
  import crp_pkg::*;

  logic [5:0] pin_cfg_r;
  logic [CRP_ROUTE_W-1:0] host_io_route_sel_r;
  logic [CRP_SLOTS-1:0] card_clock_halt_r;
  logic [CRP_CKS_W-1:0] slot_clock_source_sel_r [CRP_SLOTS];
  logic [1:0] bus_addr_r;
  logic capt_done_r;
  logic [4:0] capt_cnt_r;
  logic [CRP_DW-1:0] rdata_r;
  logic [CRP_DW-1:0] rdata_nxt;
  logic [CRP_SLOTS-1:0] clk_out_r;
  logic rst1_r;
  logic rst2_r;
  logic int_low_r;
  logic [CRP_SLOTS-1:0] cio_out_r;
  logic c4_out_r;
  logic c8_out_r;
  logic a1_s;
  logic a2_s;
  logic byp_s;
  logic pres1_s;
  logic pres2_s;
  logic slot2_full_contact_select;
  logic [CRP_PADS-1:0] pad_in;
  logic [CRP_PADS-1:0] pad_drv;
  logic [CRP_PADS-1:0] pad_o;
  logic [CRP_PADS-1:0] pad_oe;
  logic [CRP_PADS-1:0] pad_pu;
  logic [CRP_PADS-1:0] pad_lvl;
  logic [CRP_SLOTS-1:0] cio_lvl;
  logic [2:0] route_slot;
  logic route_ok;
  logic route_slot2_aux;
  logic c4_lvl;
  logic c8_lvl;
  logic c4_ours_low;
  logic c8_ours_low;
  logic [CRP_PADS-1:0] oe_d1_r, oe_d2_r, own_low;

  crp_sync #(.WIDTH(5), .INIT(5'h00)) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({card_presence_2, card_presence_1, bypass_in, addr_bit2_clock_in, addr_bit1_reset_in}),
    .q({pres2_s, pres1_s, byp_s, a2_s, a1_s})
  );

  // registers: every select and enable back to default while rst_n is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_cfg_r <= CRP_PIN_CFG_RST;
      host_io_route_sel_r <= CRP_ROUTE_RST;
      card_clock_halt_r <= CRP_HALT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        CRP_REG_PIN_CFG: pin_cfg_r <= reg_wdata[5:0];
        CRP_REG_ROUTE: host_io_route_sel_r <= reg_wdata[CRP_ROUTE_W-1:0];
        CRP_REG_HALT: card_clock_halt_r <= reg_wdata[CRP_SLOTS-1:0];
        default: ;
      endcase
    end
  end

  generate
    for (genvar n = 0; n < CRP_SLOTS; n++) begin : g_cks
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          slot_clock_source_sel_r[n] <= CRP_CKS_RST;
        end else if (reg_wr && reg_addr == CRP_REG_CKS1 + 4'(n)) begin
          slot_clock_source_sel_r[n] <= reg_wdata[CRP_CKS_W-1:0];
        end
      end

      // halt forces low; slot 3 clock is idle while slot 2 has all contacts
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          clk_out_r[n] <= 1'b0;
        end else if (card_clock_halt_r[n]) begin
          clk_out_r[n] <= 1'b0;
        end else if (n == 2 && slot2_full_contact_select) begin
          clk_out_r[n] <= 1'b0;
        end else if (slot_clock_source_sel_r[n] == CRP_CKS_PASS) begin
          clk_out_r[n] <= a2_s;
        end else begin
          clk_out_r[n] <= card_clk_src[n];
        end
      end
    end
  endgenerate

  assign slot2_full_contact_select = pin_cfg_r[CRP_B_FULL];

  // address strap capture, a fixed delay after reset release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      capt_cnt_r <= 5'h00;
      capt_done_r <= 1'b0;
      bus_addr_r <= 2'h0;
    end else if (!capt_done_r) begin
      capt_cnt_r <= capt_cnt_r + 5'h01;
      if (capt_cnt_r == CRP_ADDR_SAMPLE_CYC - 5'h01) begin
        capt_done_r <= 1'b1;
        bus_addr_r <= {a2_s, a1_s};
      end
    end
  end

  // card resets for slots 1 and 2
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rst1_r <= 1'b0;
      rst2_r <= 1'b0;
    end else begin
      rst1_r <= pin_cfg_r[CRP_B_RSEL1] ? a1_s : card_reset_int_1;
      rst2_r <= pin_cfg_r[CRP_B_RSEL2] ? a1_s : card_reset_int_2;
    end
  end

  // open-drain interrupt, low while a request stands
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_low_r <= 1'b0;
    end else begin
      int_low_r <= int_request;
    end
  end

  // host io routing: slot number in low bits, aux pair slot in top bit
  assign route_slot = host_io_route_sel_r[2:0];
  assign route_ok = route_slot != 3'h0 && route_slot <= 3'(CRP_SLOTS);
  assign route_slot2_aux = host_io_route_sel_r[3];

  // own lows take two more cycles to clear through the pin synchronisers
  always_ff @(posedge mclk) begin
    if (!rst_n) {oe_d2_r, oe_d1_r} <= '0;
    else {oe_d2_r, oe_d1_r} <= {oe_d1_r, pad_oe};
  end
  assign own_low = pad_oe | oe_d1_r | oe_d2_r;

  // slot 3 io lives on the shared pin unless slot 2 owns it
  always_comb begin
    cio_lvl = card_io_line_in;
    cio_lvl[2] = pad_lvl[CRP_P_SH4] | own_low[CRP_P_SH4] | slot2_full_contact_select;
  end

  // a low we drive ourselves is not echoed back, else the bridge latches
  assign c4_lvl = route_slot2_aux ? (slot2_full_contact_select ? pad_lvl[CRP_P_SH4] : 1'b1)
    : card_c4_contact_in;
  assign c8_lvl = route_slot2_aux ? (slot2_full_contact_select ? pad_lvl[CRP_P_SH8] : 1'b1)
    : card_c8_contact_in;
  assign c4_ours_low = route_slot2_aux ? own_low[CRP_P_SH4] : ~c4_out_r;
  assign c8_ours_low = route_slot2_aux ? own_low[CRP_P_SH8] : ~c8_out_r;

  always_comb begin
    pad_drv = '1;
    if (route_ok) begin
      pad_drv[CRP_P_HA] = cio_lvl[route_slot - 3'h1] | ~cio_out_r[route_slot - 3'h1];
    end
    pad_drv[CRP_P_XA] = c4_lvl | c4_ours_low;
    pad_drv[CRP_P_XB] = c8_lvl | c8_ours_low;
    if (slot2_full_contact_select) begin
      pad_drv[CRP_P_SH8] = pad_lvl[CRP_P_XB] | own_low[CRP_P_XB] | ~route_slot2_aux;
      pad_drv[CRP_P_SH4] = pad_lvl[CRP_P_XA] | own_low[CRP_P_XA] | ~route_slot2_aux;
    end else begin
      pad_drv[CRP_P_SH8] = card_reset_int_3;
      pad_drv[CRP_P_SH4] = cio_out_r[2];
    end
  end

  // values sent toward the cards
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cio_out_r <= '1;
      c4_out_r <= 1'b1;
      c8_out_r <= 1'b1;
    end else begin
      for (int k = 0; k < CRP_SLOTS; k++) begin
        cio_out_r[k] <= (route_ok && route_slot == 3'(k + 1)) ?
          (pad_lvl[CRP_P_HA] | own_low[CRP_P_HA]) : 1'b1;
      end
      c4_out_r <= route_slot2_aux ? 1'b1 : (pad_lvl[CRP_P_XA] | own_low[CRP_P_XA]);
      c8_out_r <= route_slot2_aux ? 1'b1 : (pad_lvl[CRP_P_XB] | own_low[CRP_P_XB]);
    end
  end

  assign pad_in = {shared_pin_slot3io_slot2c4_i, shared_pin_slot3rst_slot2c8_i,
    aux_io_b_i, aux_io_a_i, host_io_b_i, host_io_a_i};

  generate
    for (genvar p = 0; p < CRP_PADS; p++) begin : g_pad
      crp_qpad u_pad (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_i(pad_in[p]),
        .drive_val(pad_drv[p]),
        .pin_o(pad_o[p]),
        .pin_oe(pad_oe[p]),
        .pin_pu(pad_pu[p]),
        .level(pad_lvl[p])
      );
    end
  endgenerate

  // read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    case (reg_addr)
      CRP_REG_PIN_CFG: rdata_nxt = CRP_DW'(pin_cfg_r);
      CRP_REG_ROUTE: rdata_nxt = CRP_DW'(host_io_route_sel_r);
      CRP_REG_HALT: rdata_nxt = CRP_DW'(card_clock_halt_r);
      CRP_REG_STATUS: begin
        rdata_nxt[CRP_S_A1] = bus_addr_r[0];
        rdata_nxt[CRP_S_A2] = bus_addr_r[1];
        rdata_nxt[CRP_S_LOWPWR] = byp_s;
        rdata_nxt[CRP_S_CAPT] = capt_done_r;
        rdata_nxt[CRP_S_PRES1] = pres1_s;
        rdata_nxt[CRP_S_PRES2] = pres2_s;
      end
      CRP_REG_BUSADDR: rdata_nxt = {CRP_BUSADDR_HI, bus_addr_r, 1'b1, CRP_BUS_WR};
      default: begin
        if (reg_addr >= CRP_REG_CKS1 && reg_addr <= CRP_REG_CKS5) begin
          rdata_nxt = CRP_DW'(slot_clock_source_sel_r[3'(reg_addr - CRP_REG_CKS1)]);
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
  assign low_power_mode = byp_s;
  assign bus_addr_bits = bus_addr_r;
  assign presence1_pullup_en = pin_cfg_r[CRP_B_PU1];
  assign presence2_pullup_en = pin_cfg_r[CRP_B_PU2];
  assign int_pin_o = 1'b0;
  assign int_pin_oe = int_low_r;
  assign int_pullup_en = pin_cfg_r[CRP_B_INTPU];
  assign card_clock_out = clk_out_r;
  assign card_reset_out_1 = rst1_r;
  assign card_reset_out_2 = rst2_r;
  assign card_io_line_out = cio_out_r;
  assign card_c4_contact_out = c4_out_r;
  assign card_c8_contact_out = c8_out_r;
  assign {host_io_a_o, host_io_b_o, aux_io_a_o, aux_io_b_o} =
    {pad_o[CRP_P_HA], pad_o[CRP_P_HB], pad_o[CRP_P_XA], pad_o[CRP_P_XB]};
  assign {host_io_a_oe, host_io_b_oe, aux_io_a_oe, aux_io_b_oe} =
    {pad_oe[CRP_P_HA], pad_oe[CRP_P_HB], pad_oe[CRP_P_XA], pad_oe[CRP_P_XB]};
  assign {host_io_a_pu, host_io_b_pu, aux_io_a_pu, aux_io_b_pu} =
    {pad_pu[CRP_P_HA], pad_pu[CRP_P_HB], pad_pu[CRP_P_XA], pad_pu[CRP_P_XB]};
  assign shared_pin_slot3rst_slot2c8_o = pad_o[CRP_P_SH8];
  assign shared_pin_slot3rst_slot2c8_oe = pad_oe[CRP_P_SH8];
  assign shared_pin_slot3rst_slot2c8_pu = pad_pu[CRP_P_SH8];
  assign shared_pin_slot3io_slot2c4_o = pad_o[CRP_P_SH4];
  assign shared_pin_slot3io_slot2c4_oe = pad_oe[CRP_P_SH4];
  assign shared_pin_slot3io_slot2c4_pu = pad_pu[CRP_P_SH4];
endmodule // crp_top

/* File: hw/crp_pkg.sv */
// constants for the card reader pin routing block
package crp_pkg;
  localparam int CRP_AW = 4;
  localparam int CRP_DW = 8;
  localparam int CRP_SLOTS = 5;
  localparam int CRP_PADS = 6;
  localparam int CRP_CKS_W = 3;
  localparam int CRP_ROUTE_W = 4;
  // register offsets
  localparam logic [3:0] CRP_REG_PIN_CFG = 4'h0;
  localparam logic [3:0] CRP_REG_ROUTE = 4'h1;
  localparam logic [3:0] CRP_REG_HALT = 4'h2;
  localparam logic [3:0] CRP_REG_CKS1 = 4'h3;
  localparam logic [3:0] CRP_REG_CKS5 = 4'h7;
  localparam logic [3:0] CRP_REG_STATUS = 4'h8;
  localparam logic [3:0] CRP_REG_BUSADDR = 4'h9;
  // pin config fields
  localparam int CRP_B_FULL = 0;
  localparam int CRP_B_PU1 = 1;
  localparam int CRP_B_PU2 = 2;
  localparam int CRP_B_INTPU = 3;
  localparam int CRP_B_RSEL1 = 4;
  localparam int CRP_B_RSEL2 = 5;
  localparam logic [5:0] CRP_PIN_CFG_RST = 6'h06;
  localparam logic [3:0] CRP_ROUTE_RST = 4'h0;
  localparam logic [4:0] CRP_HALT_RST = 5'h00;
  localparam logic [2:0] CRP_CKS_RST = 3'h0;
  localparam logic [2:0] CRP_CKS_PASS = 3'h4;
  // status fields
  localparam int CRP_S_A1 = 0;
  localparam int CRP_S_A2 = 1;
  localparam int CRP_S_LOWPWR = 2;
  localparam int CRP_S_CAPT = 3;
  localparam int CRP_S_PRES1 = 4;
  localparam int CRP_S_PRES2 = 5;
  // serial address byte: 0100 a2 a1 1 r/w
  localparam logic [3:0] CRP_BUSADDR_HI = 4'h4;
  localparam logic CRP_BUS_WR = 1'b0;
  localparam logic CRP_BUS_RD = 1'b1;
  // address strap sampled this many master clocks after reset release
  localparam int CRP_ADDR_SAMPLE_CLKS = 22;
  localparam logic [4:0] CRP_ADDR_SAMPLE_CYC = 5'(CRP_ADDR_SAMPLE_CLKS);
  // pad indices
  localparam int CRP_P_HA = 0;
  localparam int CRP_P_HB = 1;
  localparam int CRP_P_XA = 2;
  localparam int CRP_P_XB = 3;
  localparam int CRP_P_SH8 = 4;
  localparam int CRP_P_SH4 = 5;
endpackage

/* File: hw/crp_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module crp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // crp_sync

/* File: hw/crp_qpad.sv */
// quasi-bidirectional pad: strong low, weak high
`timescale 1ns/1ps
module crp_qpad (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin_i,
  input wire logic drive_val,
  output logic pin_o,
  output logic pin_oe,
  output logic pin_pu,
  output logic level
);
  logic low_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_r <= 1'b0;
    end else begin
      low_r <= ~drive_val;
    end
  end

  // high is only the weak pull-up, so the far side may always pull low
  assign pin_o = 1'b0;
  assign pin_oe = low_r;
  assign pin_pu = 1'b1;

  crp_sync #(.WIDTH(1), .INIT(1'b1)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(pin_i),
    .q(level)
  );
endmodule // crp_qpad

/* File: tb/crp_partner.sv */
// far-side model of the host and card pads
`timescale 1ns/1ps
module crp_partner (
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pull_low,
  output logic [5:0] pad_lvl
);
  // a released line floats to its pull-up, either side may sink it
  assign pad_lvl = ~(pad_oe | pull_low);
endmodule // crp_partner

/* File: tb/crp_top_asserts.sv */
// concurrent checks on the pin routing top ports
`timescale 1ns/1ps
module crp_top_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [crp_pkg::CRP_AW-1:0] reg_addr,
  input wire logic [crp_pkg::CRP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [crp_pkg::CRP_DW-1:0] reg_rdata,
  input wire logic bypass_in,
  input wire logic low_power_mode,
  input wire logic [1:0] bus_addr_bits,
  input wire logic presence1_pullup_en,
  input wire logic presence2_pullup_en,
  input wire logic int_request,
  input wire logic int_pin_o,
  input wire logic int_pin_oe,
  input wire logic int_pullup_en,
  input wire logic [crp_pkg::CRP_SLOTS-1:0] card_clock_out,
  input wire logic host_io_a_o,
  input wire logic host_io_a_pu
);
  import crp_pkg::*;
  logic full_r, halt_r;
  logic [3:0] age_r;
  logic [5:0] up_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      full_r <= CRP_PIN_CFG_RST[CRP_B_FULL];
      halt_r <= CRP_HALT_RST[0];
    end else if (reg_wr) begin
      if (reg_addr == CRP_REG_PIN_CFG) full_r <= reg_wdata[CRP_B_FULL];
      if (reg_addr == CRP_REG_HALT) halt_r <= reg_wdata[0];
    end
  end
  // cycles since the last write, saturating
  always_ff @(posedge mclk) begin
    if (!rst_n || reg_wr) age_r <= 4'h0;
    else if (age_r != 4'hf) age_r <= age_r + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) up_r <= 6'h00;
    else if (up_r != 6'h3f) up_r <= up_r + 6'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_pu_dflt; $rose(rst_n) |-> presence1_pullup_en && presence2_pullup_en; endproperty
  a_pu_dflt: assert property (p_pu_dflt) else $error("presence pull-ups off after reset");
  property p_int_pu; $rose(rst_n) |-> !int_pullup_en; endproperty
  a_int_pu: assert property (p_int_pu) else $error("interrupt pull-up on after reset");
  property p_int; $past(rst_n) |-> !int_pin_o && int_pin_oe == $past(int_request); endproperty
  a_int: assert property (p_int) else $error("interrupt pin not open drain");
  property p_pad; host_io_a_o == 1'b0 && host_io_a_pu; endproperty
  a_pad: assert property (p_pad) else $error("host pad drives high strongly");
  property p_lowpwr; $stable(bypass_in) [*5] |-> low_power_mode == bypass_in; endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("low power mode off bypass");
  property p_halt; halt_r && age_r > 4'h1 |-> !card_clock_out[0]; endproperty
  a_halt: assert property (p_halt) else $error("halted clock runs");
  property p_slot3; full_r && age_r > 4'h1 |-> !card_clock_out[2]; endproperty
  a_slot3: assert property (p_slot3) else $error("slot 3 clock runs in full mode");
  property p_strap; up_r > 6'h1e |-> $stable(bus_addr_bits); endproperty
  a_strap: assert property (p_strap) else $error("address bits moved after capture");
  property p_baddr;
    reg_rd && reg_addr == CRP_REG_BUSADDR |=>
      reg_rdata == {CRP_BUSADDR_HI, bus_addr_bits, 1'b1, CRP_BUS_WR};
  endproperty
  a_baddr: assert property (p_baddr) else $error("bad serial address byte");
  c_full: cover property (full_r && age_r > 4'h2);
  c_baddr: cover property (reg_rd && reg_addr == CRP_REG_BUSADDR);
  c_lowpwr: cover property (low_power_mode);
endmodule // crp_top_asserts
bind crp_top crp_top_asserts i_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bypass_in(bypass_in), .low_power_mode(low_power_mode), .bus_addr_bits(bus_addr_bits),
  .presence1_pullup_en(presence1_pullup_en), .presence2_pullup_en(presence2_pullup_en),
  .int_request(int_request), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
  .int_pullup_en(int_pullup_en), .card_clock_out(card_clock_out),
  .host_io_a_o(host_io_a_o), .host_io_a_pu(host_io_a_pu));

/* File: tb/crp_top_tb.sv */
// self-checking bench for the card reader pin routing block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module crp_top_tb;
  import crp_pkg::*;
  logic mclk, rst_n, reg_wr, reg_rd, a1, a2, byp, p1, p2, irq, r1, r2, r3, s1, s2;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, b;
  logic [4:0] csrc, cko, cin, cout;
  logic [1:0] bab;
  logic lpm, pu1, pu2, ipo, ioe, ipu, ro1, ro2, c4o, c8o;
  logic [5:0] oe, po, pu, lvl, pull;
  logic [31:0] seed;
  logic [7:0] m[8];
  logic [7:0] q[$];
  int fail_count, check_count, n;
  crp_partner i_far (.pad_oe(oe), .pull_low(pull), .pad_lvl(lvl));
  crp_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_bit1_reset_in(a1),
    .addr_bit2_clock_in(a2), .bypass_in(byp), .low_power_mode(lpm), .bus_addr_bits(bab),
    .card_presence_1(p1), .card_presence_2(p2), .presence1_pullup_en(pu1),
    .presence2_pullup_en(pu2), .int_request(irq), .int_pin_o(ipo), .int_pin_oe(ioe),
    .int_pullup_en(ipu), .card_clk_src(csrc), .card_clock_out(cko), .card_reset_int_1(r1),
    .card_reset_int_2(r2), .card_reset_int_3(r3), .card_reset_out_1(ro1),
    .card_reset_out_2(ro2), .card_io_line_in(cin), .card_io_line_out(cout),
    .card_c4_contact_in(1'b1), .card_c8_contact_in(1'b1), .card_c4_contact_out(c4o),
    .card_c8_contact_out(c8o), .host_io_a_i(lvl[0]), .host_io_a_o(po[0]),
    .host_io_a_oe(oe[0]), .host_io_a_pu(pu[0]), .host_io_b_i(lvl[1]), .host_io_b_o(po[1]),
    .host_io_b_oe(oe[1]), .host_io_b_pu(pu[1]), .aux_io_a_i(lvl[2]), .aux_io_a_o(po[2]),
    .aux_io_a_oe(oe[2]), .aux_io_a_pu(pu[2]), .aux_io_b_i(lvl[3]), .aux_io_b_o(po[3]),
    .aux_io_b_oe(oe[3]), .aux_io_b_pu(pu[3]), .shared_pin_slot3rst_slot2c8_i(lvl[4]),
    .shared_pin_slot3rst_slot2c8_o(po[4]), .shared_pin_slot3rst_slot2c8_oe(oe[4]),
    .shared_pin_slot3rst_slot2c8_pu(pu[4]), .shared_pin_slot3io_slot2c4_i(lvl[5]),
    .shared_pin_slot3io_slot2c4_o(po[5]), .shared_pin_slot3io_slot2c4_oe(oe[5]),
    .shared_pin_slot3io_slot2c4_pu(pu[5]));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ex(int a);
    if (a < 8) return m[a];
    if (a == 8) return {2'b00, p2, p1, 1'b1, byp, s2, s1};
    return a == 9 ? {4'h4, s2, s1, 2'b10} : 8'h00;
  endfunction
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a < 8) m[a] = d & (a == 0 ? 8'h3f : a == 1 ? 8'h0f : a == 2 ? 8'h1f : 8'h07);
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic rd_all();
    for (int a = 0; a < 16; a++) rd(4'(a), ex(a));
  endtask
  task automatic reset(logic x1, logic x2);
    s1 = x1;
    s2 = x2;
    @(posedge mclk);
    a1 <= x1;
    a2 <= x2;
    rst_n <= 1'b0;
    tick(6);
    @(posedge mclk) rst_n <= 1'b1;
    m = '{default: 8'h00};
    m[0] = {2'b00, CRP_PIN_CFG_RST};
    tick(30);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    seed = 32'h42df;
    {rst_n, reg_wr, reg_rd, a1, a2, byp, p2, irq, r1, r2, r3} = '0;
    p1 = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    csrc = 5'h00;
    cin = 5'h1f;
    pull = 6'h00;
    reset(1'b1, 1'b0);
    `CHK({pu1, pu2, ipu, ipo}, 4'b1100)
    `CHK({po, pu}, 12'h03f)
    `CHK(bab, 2'b01)
    rd_all();
    for (int i = 0; i < 24; i++) wr(4'(xs()), 8'(xs()));
    rd_all();
    wr(0, 8'h38);
    `CHK({pu1, pu2, ipu}, 3'b001)
    wr(2, 8'h00);
    for (int s = 3; s < 8; s++) wr(4'(s), {5'h00, CRP_CKS_PASS});
    tick(4);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      b = 8'(xs());
      {a1, a2, csrc, irq} <= b;
      q.push_back(b);
      #1;
      if (q.size() > 3) begin
        `CHK(cko, {5{q[q.size()-4][6]}})
        `CHK({ro1, ro2}, {2{q[q.size()-4][7]}})
        `CHK(ioe, q[q.size()-2][0])
      end
    end
    wr(2, 8'h1f);
    tick(2);
    `CHK(cko, 5'h00)
    @(posedge mclk) a2 <= 1'b1;
    wr(2, 8'h00);
    wr(0, 8'h01);
    tick(4);
    `CHK(cko, 5'h1b)
    wr(1, 8'h08);
    for (int p = 2; p < 4; p++) begin
      @(posedge mclk) pull[p] <= 1'b1;
      tick(4);
      `CHK(oe[7-p], 1'b1)
      @(posedge mclk) pull[p] <= 1'b0;
      tick(4);
      `CHK(oe[5:4], 2'b00)
    end
    wr(0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) r3 <= k[0];
      tick(2);
      `CHK(oe[4], !k[0])
    end
    wr(1, 8'h03);
    @(posedge mclk) pull[0] <= 1'b1;
    tick(4);
    `CHK({cout[2], oe[5]}, 2'b01)
    @(posedge mclk) pull[0] <= 1'b0;
    wr(1, 8'h01);
    @(posedge mclk) cin[0] <= 1'b0;
    tick(4);
    `CHK(oe[1:0], 2'b01)
    @(posedge mclk) cin[0] <= 1'b1;
    @(posedge mclk) pull[3:2] <= 2'b11;
    tick(4);
    `CHK({c4o, c8o}, 2'b00)
    @(posedge mclk) pull[3:2] <= 2'b00;
    @(posedge mclk) byp <= 1'b1;
    n = 0;
    while (lpm !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    `CHK(lpm, 1'b1)
    if (n < 10) begin
      reset(1'b0, 1'b1);
      `CHK({pu1, pu2, ipu, oe}, 9'h180)
      `CHK(bab, 2'b10)
      `CHK(cko, csrc)
      @(posedge mclk) {r1, r2} <= 2'b10;
      tick(2);
      `CHK({ro1, ro2}, 2'b10)
      rd_all();
    end
    tally_and_finish();
  end
endmodule // crp_top_tb
